// ---- bench/tsb_host_model.sv ----
`timescale 1ns/100ps
module tsb_host_model (
	input  wire logic	clock,
	input  wire logic	bus_sda,
	output logic		scl,
	output logic		sda
);
	logic	in_frame;

	// Lines idle high between frames
	initial begin
		scl = 1'b1;
		sda = 1'b1;
		in_frame = 1'b0;
	end

	////////////////////////////////////////
	// Wait n clocks, always landing on a falling edge
	task automatic qw(input int n);
		repeat (n) @(negedge clock);
	endtask : qw

	// Start; a repeated start first lifts data under a low clock
	task automatic start_cond();
		if (in_frame) begin
			scl = 1'b0;
			qw(4);
			sda = 1'b1;
			qw(4);
			scl = 1'b1;
			qw(4);
		end
		sda = 1'b0;
		qw(4);
		in_frame = 1'b1;
	endtask : start_cond

	// One clock: data set while low, sampled mid high
	task automatic clk_bit(input logic b, output logic s);
		scl = 1'b0;
		qw(4);
		sda = b;
		qw(4);
		scl = 1'b1;
		qw(4);
		s = bus_sda;
		qw(4);
	endtask : clk_bit

	// Byte MSB first, ninth clock released for ack or as read nack
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(tx[i], rx[i]);
		end
		clk_bit(1'b1, ack);
	endtask : xfer

	// Stop: data low under a low clock, then rising with clock high
	task automatic stop_cond();
		scl = 1'b0;
		qw(4);
		sda = 1'b0;
		qw(4);
		scl = 1'b1;
		qw(4);
		sda = 1'b1;
		qw(4);
		in_frame = 1'b0;
	endtask : stop_cond

	// Park both lines to stall the bus
	task automatic hold(input logic c, input logic d, input int n);
		scl = c;
		sda = d;
		qw(n);
	endtask : hold
endmodule : tsb_host_model

// ---- bench/tsb_smbus_slave_tb_top.sv ----
`timescale 1ns/100ps
module tsb_smbus_slave_tb_top;
	localparam logic [7:0] WA = {tsb_pkg::DEV_ADDR, 1'b0};
	localparam logic [7:0] RA = {tsb_pkg::DEV_ADDR, 1'b1};
	localparam logic [7:0] ALR = {tsb_pkg::ARA_ADDR, 1'b1};

	logic				clock;
	logic				resetn;
	logic				host_scl;
	logic				host_sda;
	logic				bus_sda;
	logic				sda_out;
	logic				sda_oe_n;
	logic				alarm_oe_n;
	logic				alarm_out;
	logic				status_pending;
	logic [7:0]			reg_pointer;
	tsb_pkg::tsb_reg_write_type	reg_write;
	tsb_pkg::tsb_reg_write_type	wr_seen;
	logic				standby;
	logic				oneshot;
	int				n_fail;
	int				check_count;
	int				n_wr;
	int				n_shot;
	int				cycles;

	// Wired-AND data line
	assign bus_sda = host_sda & (sda_oe_n | sda_out);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	tsb_smbus_slave #(
		.TIMEOUT_CYCLES	(200)
	) tsb_smbus_slave_i (
		.clock			(clock),
		.resetn			(resetn),
		.scl_in			(host_scl),
		.serial_data_line_in	(bus_sda),
		.serial_data_line_out	(sda_out),
		.serial_data_line_oe_n	(sda_oe_n),
		.alarm_out		(alarm_out),
		.alarm_oe_n		(alarm_oe_n),
		.status_pending		(status_pending),
		.reg_rd_data		(reg_pointer ^ 8'hA5),
		.reg_pointer		(reg_pointer),
		.reg_write		(reg_write),
		.monitor_standby_select	(standby),
		.oneshot_start		(oneshot)
	);

	tsb_host_model tsb_host_model_i (
		.clock		(clock),
		.bus_sda	(bus_sda),
		.scl		(host_scl),
		.sda		(host_sda)
	);

	// Count register-side pulses; cut a hang short
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (reg_write.valid === 1'b1) begin
			wr_seen <= reg_write;
			n_wr <= n_wr + 1;
		end
		if (oneshot === 1'b1) begin
			n_shot <= n_shot + 1;
		end
		if (cycles == 60000) begin
			n_fail++;
			wrap_up();
		end
	end

	////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wrap_up();
		if (n_fail == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	// Address byte, n more bytes (first in d[7:0]), stop
	task automatic xact(input logic [7:0] ab, input logic [23:0] d, input int n,
		output logic [3:0] ak, output logic [7:0] rd);
		ak = 4'hF;
		tsb_host_model_i.start_cond();
		tsb_host_model_i.xfer(ab, rd, ak[0]);
		for (int k = 0; k < n; k++) begin
			tsb_host_model_i.xfer(d[8*k +: 8], rd, ak[k+1]);
		end
		tsb_host_model_i.stop_cond();
	endtask : xact

	////////////////////////////////////////
	task automatic t_reset();
		check("data oe_n", 8'(sda_oe_n), 8'h01);
		check("alarm oe_n", 8'(alarm_oe_n), 8'h01);
		check("standby", 8'(standby), 8'h00);
		check("alarm out", 8'(alarm_out), 8'h00);
		check("pointer reset", reg_pointer, tsb_pkg::PTR_RESET);
	endtask : t_reset

	// Pointer, data, then a third byte to be refused
	task automatic t_write();
		logic [3:0]	ak;
		logic [7:0]	rd;
		int		n0;
		n0 = n_wr;
		xact(WA, 24'h775A31, 3, ak, rd);
		check("write acks", 8'(ak), 8'h08);
		check("pointer", reg_pointer, 8'h31);
		check("write addr", wr_seen.addr, 8'h31);
		check("write data", wr_seen.data, 8'h5A);
		check("write pulses", 8'(n_wr - n0), 8'h01);
	endtask : t_write

	// Read at kept pointer, pointer-only write, read there
	task automatic t_read();
		logic [3:0]	ak;
		logic [7:0]	rd;
		int		n0;
		n0 = n_wr;
		xact(RA, 24'h0000FF, 1, ak, rd);
		check("read ack", 8'(ak[0]), 8'h00);
		check("read data", rd, 8'h31 ^ 8'hA5);
		xact(WA, 24'h000005, 1, ak, rd);
		check("pointer only", reg_pointer, 8'h05);
		check("no write", 8'(n_wr - n0), 8'h00);
		xact(RA, 24'h0000FF, 1, ak, rd);
		check("read new", rd, 8'h05 ^ 8'hA5);
	endtask : t_read

	// Foreign addresses, write to alert address, alert read with no alarm
	task automatic t_foreign();
		logic [3:0]	ak;
		logic [7:0]	rd;
		logic [31:0]	bad;
		bad = {8'h9A, 8'h18, ALR, 8'hD8};
		for (int k = 0; k < 4; k++) begin
			xact(bad[8*k +: 8], 24'h000044, 1, ak, rd);
			check("foreign ack", 8'(ak[0]), 8'h01);
		end
		check("pointer kept", reg_pointer, 8'h05);
	endtask : t_foreign

	task automatic t_standby();
		logic [3:0]	ak;
		logic [7:0]	rd;
		int		n0;
		n0 = n_shot;
		xact(WA, {8'h00, 8'h40, tsb_pkg::PTR_CFG1_WR}, 2, ak, rd);
		check("standby on", 8'(standby), 8'h01);
		xact(WA, {16'h0000, tsb_pkg::PTR_CFG1_RD}, 1, ak, rd);
		xact(RA, 24'h0000FF, 1, ak, rd);
		check("config readback", rd, 8'h40);
		xact(WA, {8'h00, 8'hC3, tsb_pkg::PTR_ONESHOT}, 2, ak, rd);
		check("oneshot acks", 8'(ak[2:0]), 8'h00);
		check("oneshot pulses", 8'(n_shot - n0), 8'h01);
		check("still standby", 8'(standby), 8'h01);
		xact(WA, 24'h00200B, 2, ak, rd);
		check("limit data", wr_seen.data, 8'h20);
		status_pending = 1'b1;
		repeat (4) @(negedge clock);
		check("standby alarm", 8'(alarm_oe_n), 8'h00);
		xact(RA, 24'h0000FF, 1, ak, rd);
		check("standby read", rd, 8'h0B ^ 8'hA5);
		xact(WA, {8'h00, 8'h00, tsb_pkg::PTR_CFG1_WR}, 2, ak, rd);
		check("standby off", 8'(standby), 8'h00);
	endtask : t_standby

	// Alert answers: held, lost to a lower address, released, unanswered
	task automatic t_alarm();
		logic [3:0]	ak;
		logic [7:0]	rd;
		check("alarm", 8'(alarm_oe_n), 8'h00);
		xact(ALR, 24'h0000FF, 1, ak, rd);
		check("alert ack", 8'(ak[0]), 8'h00);
		check("alert answer", rd, RA);
		check("alarm held", 8'(alarm_oe_n), 8'h00);
		status_pending = 1'b0;
		xact(ALR, 24'h000091, 1, ak, rd);
		check("lost answer", 8'(alarm_oe_n), 8'h00);
		xact(ALR, 24'h0000FF, 1, ak, rd);
		check("released", 8'(alarm_oe_n), 8'h01);
		xact(ALR, 24'h0000FF, 1, ak, rd);
		check("alert idle", 8'(ak[0]), 8'h01);
	endtask : t_alarm

	// Clock stall during ack, then data stall under a high clock
	task automatic t_timeout(input logic [7:0] cfg);
		logic [3:0]	ak;
		logic [7:0]	rd;
		logic		b;
		if (cfg !== tsb_pkg::ALERT_CFG_RESET)
			xact(WA, {8'h00, cfg, tsb_pkg::PTR_ALERT_CFG}, 2, ak, rd);
		else
			xact(WA, {16'h0000, tsb_pkg::PTR_ALERT_CFG}, 1, ak, rd);
		xact(RA, 24'h0000FF, 1, ak, rd);
		check("timeout reg", rd, cfg);
		tsb_host_model_i.start_cond();
		for (int i = 7; i >= 0; i--)
			tsb_host_model_i.clk_bit(WA[i], b);
		tsb_host_model_i.hold(1'b0, 1'b1, 250);
		check("clock stall", 8'(sda_oe_n), 8'(cfg[7] | cfg[6]));
		// Close the ack clock so a held acknowledge lets go before the stop
		tsb_host_model_i.clk_bit(1'b1, b);
		tsb_host_model_i.stop_cond();
		tsb_host_model_i.start_cond();
		tsb_host_model_i.hold(1'b1, 1'b0, 250);
		tsb_host_model_i.xfer(WA, rd, b);
		check("data stall", 8'(b), 8'(cfg[6]));
		tsb_host_model_i.stop_cond();
	endtask : t_timeout

	////////////////////////////////////////
	initial begin
		resetn = 1'b0;
		status_pending = 1'b0;
		n_fail = 0;
		check_count = 0;
		n_wr = 0;
		n_shot = 0;
		cycles = 0;
		repeat (16) @(negedge clock);
		resetn = 1'b1;
		repeat (8) @(negedge clock);
		t_reset();
		t_write();
		t_read();
		t_foreign();
		t_standby();
		t_alarm();
		t_timeout(tsb_pkg::ALERT_CFG_RESET);
		t_timeout(8'h81);
		t_timeout(8'h41);
		wrap_up();
	end
endmodule : tsb_smbus_slave_tb_top

// ---- hw/tsb_line_timer.sv ----
`timescale 1ns/100ps
module tsb_line_timer #(
	parameter int LIMIT = 2500000
) (
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic run,
	output logic      expired
);
	localparam int W = $clog2(LIMIT + 1);

	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;
	logic         expired_next;

	// Counts while the line is stuck, clears otherwise
	always_comb begin
		count_next   = '0;
		expired_next = 1'b0;
		if (run) begin
			if (count_reg == W'(LIMIT - 1)) begin
				expired_next = 1'b1;
				count_next   = '0;
			end else begin
				count_next = count_reg + W'(1);
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			count_reg <= '0;
			expired   <= 1'b0;
		end else begin
			count_reg <= count_next;
			expired   <= expired_next;
		end
	end
endmodule : tsb_line_timer

// ---- hw/tsb_pkg.sv ----
package tsb_pkg;

	// Bus addresses
	localparam logic [6:0] DEV_ADDR      = 7'h4C;
	localparam logic [6:0] ARA_ADDR      = 7'h0C;

	// Register pointer values
	localparam logic [7:0] PTR_CFG1_RD   = 8'h03;
	localparam logic [7:0] PTR_CFG1_WR   = 8'h09;
	localparam logic [7:0] PTR_ONESHOT   = 8'h0F;
	localparam logic [7:0] PTR_ALERT_CFG = 8'h22;
	localparam logic [7:0] PTR_RESET     = 8'h00;

	// Reset values
	localparam logic [7:0] CFG1_RESET      = 8'h00;
	localparam logic [7:0] ALERT_CFG_RESET = 8'h01;

	// Field positions
	localparam int SCL_TO_BIT  = 7;
	localparam int SDA_TO_BIT  = 6;
	localparam int STANDBY_BIT = 6;

	// Timing
	localparam int CLOCK_MHZ      = 100;
	localparam int TIMEOUT_US     = 25000;
	localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLOCK_MHZ;

	// Serial slave states
	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_ADDR     = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_WR_BYTE  = 3'b011,
		ST_WR_ACK   = 3'b100,
		ST_RD_BYTE  = 3'b101,
		ST_RD_ACK   = 3'b110
	} tsb_state_type;

	// Register write carried to the register map
	typedef struct packed {
		logic       valid;
		logic [7:0] addr;
		logic [7:0] data;
	} tsb_reg_write_type;

endpackage : tsb_pkg

// ---- hw/tsb_smbus_slave.sv ----
`timescale 1ns/100ps
module tsb_smbus_slave #(
	parameter int TIMEOUT_CYCLES = tsb_pkg::TIMEOUT_CYCLES
) (
	input  wire logic                       clock,
	input  wire logic                       resetn,
	input  wire logic                       scl_in,
	input  wire logic                       serial_data_line_in,
	output logic                            serial_data_line_out,
	output logic                            serial_data_line_oe_n,
	output logic                            alarm_out,
	output logic                            alarm_oe_n,
	input  wire logic                       status_pending,
	input  wire logic [7:0]                 reg_rd_data,
	output logic [7:0]                      reg_pointer,
	output tsb_pkg::tsb_reg_write_type      reg_write,
	output logic                            monitor_standby_select,
	output logic                            oneshot_start
);
	////////////////////////////////////////////////////////////////////////////////
	// Line sampling and edge detection
	logic scl_s;
	logic sda_s;
	logic scl_d_reg;
	logic sda_d_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic scl_to_exp;
	logic sda_to_exp;

	tsb_sync #(.RESET_VAL(1'b1)) u_scl_sync (
		.clock    (clock),
		.resetn   (resetn),
		.async_in (scl_in),
		.sync_out (scl_s)
	);

	tsb_sync #(.RESET_VAL(1'b1)) u_sda_sync (
		.clock    (clock),
		.resetn   (resetn),
		.async_in (serial_data_line_in),
		.sync_out (sda_s)
	);

	// Delayed copies of synchronised lines
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	// Clock edges, start and stop while clock high
	assign scl_rise   = scl_s & ~scl_d_reg;
	assign scl_fall   = ~scl_s & scl_d_reg;
	assign start_seen = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_seen  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	////////////////////////////////////////////////////////////////////////////////
	// Slave state machine
	tsb_pkg::tsb_state_type state_reg;
	tsb_pkg::tsb_state_type state_next;
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic [7:0] tx_reg;
	logic [7:0] tx_next;
	logic [3:0] bit_cnt_reg;
	logic [3:0] bit_cnt_next;
	logic [1:0] byte_idx_reg;
	logic [1:0] byte_idx_next;
	logic       rw_reg;
	logic       rw_next;
	logic       ara_mode_reg;
	logic       ara_mode_next;
	logic       sda_oe_n_reg;
	logic       sda_oe_n_next;
	logic [7:0] pointer_reg;
	logic [7:0] pointer_next;
	logic       data_wr;
	logic       ara_done;
	logic       byte_full;
	logic       match_dev;
	logic       match_ara;
	logic [7:0] rd_byte;
	logic [7:0] cfg1_reg;
	logic [7:0] alert_cfg_reg;
	logic       alarm_active_reg;

	assign byte_full = (bit_cnt_reg == 4'h8);
	assign match_dev = (shift_reg[7:1] == tsb_pkg::DEV_ADDR);
	assign match_ara = (shift_reg[7:1] == tsb_pkg::ARA_ADDR) & shift_reg[0]
	                 & alarm_active_reg;

	// Read data selected by the pointer
	always_comb begin
		case (pointer_reg)
			tsb_pkg::PTR_CFG1_RD:   rd_byte = cfg1_reg;
			tsb_pkg::PTR_ALERT_CFG: rd_byte = alert_cfg_reg;
			default:                rd_byte = reg_rd_data;
		endcase
	end

	// Next state of the serial engine
	always_comb begin
		state_next    = state_reg;
		shift_next    = shift_reg;
		tx_next       = tx_reg;
		bit_cnt_next  = bit_cnt_reg;
		byte_idx_next = byte_idx_reg;
		rw_next       = rw_reg;
		ara_mode_next = ara_mode_reg;
		sda_oe_n_next = sda_oe_n_reg;
		pointer_next  = pointer_reg;
		data_wr       = 1'b0;
		ara_done      = 1'b0;
		if (scl_rise && (state_reg == tsb_pkg::ST_ADDR || state_reg == tsb_pkg::ST_WR_BYTE
		                 || state_reg == tsb_pkg::ST_RD_BYTE)) begin
			shift_next   = {shift_reg[6:0], sda_s};
			bit_cnt_next = bit_cnt_reg + 4'h1;
		end
		case (state_reg)
			tsb_pkg::ST_IDLE: begin
				sda_oe_n_next = 1'b1;
			end
			tsb_pkg::ST_ADDR: begin
				if (scl_fall && byte_full) begin
					if (match_dev || match_ara) begin
						state_next    = tsb_pkg::ST_ADDR_ACK;
						sda_oe_n_next = 1'b0;
						rw_next       = shift_reg[0];
						ara_mode_next = match_ara & ~match_dev;
						byte_idx_next = 2'h0;
					end else begin
						state_next = tsb_pkg::ST_IDLE;
					end
				end
			end
			tsb_pkg::ST_ADDR_ACK: begin
				if (scl_fall) begin
					bit_cnt_next = 4'h0;
					if (rw_reg) begin
						tx_next       = ara_mode_reg ? {tsb_pkg::DEV_ADDR, 1'b1} : rd_byte;
						sda_oe_n_next = tx_next[7];
						state_next    = tsb_pkg::ST_RD_BYTE;
					end else begin
						sda_oe_n_next = 1'b1;
						state_next    = tsb_pkg::ST_WR_BYTE;
					end
				end
			end
			tsb_pkg::ST_WR_BYTE: begin
				if (scl_fall && byte_full) begin
					if (byte_idx_reg == 2'h0) begin
						pointer_next  = shift_reg;
						state_next    = tsb_pkg::ST_WR_ACK;
						sda_oe_n_next = 1'b0;
					end else if (byte_idx_reg == 2'h1) begin
						data_wr       = 1'b1;
						state_next    = tsb_pkg::ST_WR_ACK;
						sda_oe_n_next = 1'b0;
					end else begin
						state_next = tsb_pkg::ST_IDLE;
					end
					byte_idx_next = (byte_idx_reg == 2'h2) ? 2'h2 : byte_idx_reg + 2'h1;
				end
			end
			tsb_pkg::ST_WR_ACK: begin
				if (scl_fall) begin
					sda_oe_n_next = 1'b1;
					bit_cnt_next  = 4'h0;
					state_next    = tsb_pkg::ST_WR_BYTE;
				end
			end
			tsb_pkg::ST_RD_BYTE: begin
				if (scl_rise && sda_oe_n_reg && !sda_s && ara_mode_reg) begin
					state_next    = tsb_pkg::ST_IDLE;
					sda_oe_n_next = 1'b1;
				end else if (scl_fall && byte_full) begin
					state_next    = tsb_pkg::ST_RD_ACK;
					sda_oe_n_next = 1'b1;
					ara_done      = ara_mode_reg;
				end else if (scl_fall) begin
					tx_next       = {tx_reg[6:0], 1'b1};
					sda_oe_n_next = tx_reg[6];
				end
			end
			tsb_pkg::ST_RD_ACK: begin
				if (scl_fall) begin
					state_next = tsb_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next    = tsb_pkg::ST_IDLE;
				sda_oe_n_next = 1'b1;
			end
		endcase
		if (start_seen) begin
			state_next    = tsb_pkg::ST_ADDR;
			bit_cnt_next  = 4'h0;
			sda_oe_n_next = 1'b1;
		end
		if (stop_seen || scl_to_exp || sda_to_exp) begin
			state_next    = tsb_pkg::ST_IDLE;
			sda_oe_n_next = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_reg    <= tsb_pkg::ST_IDLE;
			shift_reg    <= 8'h00;
			tx_reg       <= 8'hFF;
			bit_cnt_reg  <= 4'h0;
			byte_idx_reg <= 2'h0;
			rw_reg       <= 1'b0;
			ara_mode_reg <= 1'b0;
			sda_oe_n_reg <= 1'b1;
			pointer_reg  <= tsb_pkg::PTR_RESET;
		end else begin
			state_reg    <= state_next;
			shift_reg    <= shift_next;
			tx_reg       <= tx_next;
			bit_cnt_reg  <= bit_cnt_next;
			byte_idx_reg <= byte_idx_next;
			rw_reg       <= rw_next;
			ara_mode_reg <= ara_mode_next;
			sda_oe_n_reg <= sda_oe_n_next;
			pointer_reg  <= pointer_next;
		end
	end

	assign serial_data_line_out  = 1'b0;
	assign serial_data_line_oe_n = sda_oe_n_reg;
	assign reg_pointer           = pointer_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Inactivity timeouts
	logic scl_to_run;
	logic sda_to_run;

	// Run only when enabled and inside a transfer
	assign scl_to_run = alert_cfg_reg[tsb_pkg::SCL_TO_BIT] & ~scl_s
	                  & (state_reg != tsb_pkg::ST_IDLE);
	assign sda_to_run = alert_cfg_reg[tsb_pkg::SDA_TO_BIT] & ~sda_s
	                  & (state_reg != tsb_pkg::ST_IDLE);

	tsb_line_timer #(.LIMIT(TIMEOUT_CYCLES)) u_scl_timer (
		.clock   (clock),
		.resetn  (resetn),
		.run     (scl_to_run),
		.expired (scl_to_exp)
	);

	tsb_line_timer #(.LIMIT(TIMEOUT_CYCLES)) u_sda_timer (
		.clock   (clock),
		.resetn  (resetn),
		.run     (sda_to_run),
		.expired (sda_to_exp)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Local registers, write strobe and alarm
	logic [7:0]                 cfg1_next;
	logic [7:0]                 alert_cfg_next;
	logic                       oneshot_next;
	tsb_pkg::tsb_reg_write_type wr_next;
	logic                       alarm_active_next;

	// Register writes, conversion trigger, alarm latch
	always_comb begin
		cfg1_next         = cfg1_reg;
		alert_cfg_next    = alert_cfg_reg;
		oneshot_next      = 1'b0;
		wr_next.valid     = data_wr;
		wr_next.addr      = pointer_reg;
		wr_next.data      = shift_reg;
		if (data_wr) begin
			case (pointer_reg)
				tsb_pkg::PTR_CFG1_WR:   cfg1_next = shift_reg;
				tsb_pkg::PTR_ALERT_CFG: alert_cfg_next = shift_reg;
				tsb_pkg::PTR_ONESHOT:   oneshot_next = 1'b1;
				default:                cfg1_next = cfg1_reg;
			endcase
		end
		// Set wins over release
		alarm_active_next = status_pending
		                  | (alarm_active_reg & ~(ara_done & ~status_pending));
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cfg1_reg         <= tsb_pkg::CFG1_RESET;
			alert_cfg_reg    <= tsb_pkg::ALERT_CFG_RESET;
			oneshot_start    <= 1'b0;
			reg_write        <= '0;
			alarm_active_reg <= 1'b0;
			alarm_oe_n       <= 1'b1;
		end else begin
			cfg1_reg         <= cfg1_next;
			alert_cfg_reg    <= alert_cfg_next;
			oneshot_start    <= oneshot_next;
			reg_write        <= wr_next;
			alarm_active_reg <= alarm_active_next;
			alarm_oe_n       <= ~alarm_active_next;
		end
	end

	assign alarm_out              = 1'b0;
	assign monitor_standby_select = cfg1_reg[tsb_pkg::STANDBY_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence ack_start_s;
		state_reg == tsb_pkg::ST_ADDR && scl_fall && byte_full && match_dev && !start_seen
		&& !stop_seen && !scl_to_exp && !sda_to_exp;
	endsequence

	sequence oneshot_pulse_s;
		oneshot_start ##1 !oneshot_start;
	endsequence

	ack_drive_a: assert property (@(posedge clock) disable iff (!resetn)
		state_reg == tsb_pkg::ST_ADDR_ACK |-> !serial_data_line_oe_n)
		else $error("address acknowledge not driven");

	ack_entry_a: assert property (@(posedge clock) disable iff (!resetn)
		ack_start_s |=> state_reg == tsb_pkg::ST_ADDR_ACK)
		else $error("own address not acknowledged");

	idle_release_a: assert property (@(posedge clock) disable iff (!resetn)
		(scl_to_exp || sda_to_exp) |=> state_reg == tsb_pkg::ST_IDLE && serial_data_line_oe_n)
		else $error("timeout did not release bus");

	pointer_load_a: assert property (@(posedge clock) disable iff (!resetn)
		state_reg == tsb_pkg::ST_WR_BYTE && scl_fall && byte_full && byte_idx_reg == 2'h0
		&& !start_seen && !stop_seen |=> pointer_reg == $past(shift_reg))
		else $error("pointer not loaded from first byte");

	oneshot_a: assert property (@(posedge clock) disable iff (!resetn)
		data_wr && pointer_reg == tsb_pkg::PTR_ONESHOT |=> oneshot_pulse_s)
		else $error("one-shot pulse wrong");

	standby_a: assert property (@(posedge clock) disable iff (!resetn)
		data_wr && pointer_reg == tsb_pkg::PTR_CFG1_WR
		|=> monitor_standby_select == $past(shift_reg[6]))
		else $error("standby bit not written");

	alarm_set_a: assert property (@(posedge clock) disable iff (!resetn)
		status_pending |=> !alarm_oe_n)
		else $error("alarm not driven on pending status");

	alarm_hold_a: assert property (@(posedge clock) disable iff (!resetn)
		!alarm_oe_n && !ara_done |=> !alarm_oe_n)
		else $error("alarm released without alert answer");

	timeout_cfg_a: assert property (@(posedge clock) disable iff (!resetn)
		data_wr && pointer_reg == tsb_pkg::PTR_ALERT_CFG
		|=> alert_cfg_reg[7:6] == $past(shift_reg[7:6]))
		else $error("timeout enables not written");

endmodule : tsb_smbus_slave

// ---- hw/tsb_sync.sv ----
`timescale 1ns/100ps
module tsb_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic async_in,
	output logic      sync_out
);
	logic first_reg;
	logic first_next;
	logic second_next;

	// Two stages, first stage feeds only the second
	always_comb begin
		first_next  = async_in;
		second_next = first_reg;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			first_reg <= RESET_VAL;
			sync_out  <= RESET_VAL;
		end else begin
			first_reg <= first_next;
			sync_out  <= second_next;
		end
	end
endmodule : tsb_sync
